/* rpo_pkg.sv */
// Package: offsets, field positions, reset values and types of the override register bank
package rpo_pkg;

    // Register offsets
    localparam logic [7:0] OFS_POWER_DOWN   = 8'h01;
    localparam logic [7:0] OFS_OVERRIDE     = 8'h02;
    localparam logic [7:0] OFS_RSVD_A       = 8'h03;
    localparam logic [7:0] OFS_RSVD_B       = 8'h04;
    localparam logic [7:0] OFS_RSVD_C       = 8'h05;
    localparam logic [7:0] OFS_SLAVE_CTRL   = 8'h06;
    localparam logic [7:0] OFS_RESET_CTRL   = 8'h07;
    localparam logic [7:0] OFS_PIN_OVERRIDE = 8'h08;

    // Field positions
    localparam int BIT_OVR_PRESENT     = 7;
    localparam int BIT_PRESENT_VALUE   = 6;
    localparam int BIT_OVR_POWER_DOWN  = 0;
    localparam int BIT_REG_ENABLE      = 3;
    localparam int BIT_RESET_REGISTERS = 6;
    localparam int BIT_RESET_MASTER    = 5;
    localparam int BIT_OVR_THRESHOLD   = 6;
    localparam int BIT_OVR_RX_DETECT   = 3;

    // Reset values
    localparam logic [7:0] RST_POWER_DOWN   = 8'h00;
    localparam logic [7:0] RST_OVERRIDE     = 8'h00;
    localparam logic [7:0] RST_RSVD         = 8'h00;
    localparam logic [7:0] RST_SLAVE_CTRL   = 8'h10;
    localparam logic [7:0] RST_RESET_CTRL   = 8'h01;
    localparam logic [7:0] RST_PIN_OVERRIDE = 8'h00;

    // Default slave address; the real part takes it from strap pins
    localparam logic [6:0] DEFAULT_SLAVE_ADDR = 7'h18;

    // Bit count of one SMBus byte
    localparam logic [3:0] BYTE_BITS = 4'h8;

    // Stored register contents
    typedef struct packed {
        logic [7:0] power_down;
        logic [7:0] override_ctl;
        logic [7:0] rsvd_a;
        logic [7:0] rsvd_b;
        logic [7:0] rsvd_c;
        logic [7:0] slave_ctl;
        logic [7:0] reset_ctl;
        logic [7:0] pin_override;
    } rpo_regs_t;

    localparam rpo_regs_t RST_REGS = '{
        power_down:   RST_POWER_DOWN,
        override_ctl: RST_OVERRIDE,
        rsvd_a:       RST_RSVD,
        rsvd_b:       RST_RSVD,
        rsvd_c:       RST_RSVD,
        slave_ctl:    RST_SLAVE_CTRL,
        reset_ctl:    RST_RESET_CTRL,
        pin_override: RST_PIN_OVERRIDE
    };

    // One register write from the bus engine
    typedef struct packed {
        logic       en;
        logic [7:0] addr;
        logic [7:0] data;
    } rpo_write_t;

    // Bus engine states, Gray coded along the write path
    typedef enum logic [3:0] {
        RPO_IDLE      = 4'h0,
        RPO_ADDR      = 4'h1,
        RPO_ADDR_ACK  = 4'h3,
        RPO_OFFSET    = 4'h2,
        RPO_OFS_ACK   = 4'h6,
        RPO_WDATA     = 4'h7,
        RPO_WDATA_ACK = 4'h5,
        RPO_RDATA     = 4'h4,
        RPO_RDATA_ACK = 4'hc
    } rpo_state_t;

endpackage

/* rpo_override_regs.sv */
// Override and reset register bank behind an SMBus slave, offsets 0x01 to 0x08
`timescale 1ns/100ps
`default_nettype none

module rpo_override_regs #(
    parameter logic [6:0] SLAVE_ADDR = rpo_pkg::DEFAULT_SLAVE_ADDR
) (
    input  wire logic       clock,
    input  wire logic       nrst,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    input  wire logic [7:0] channel_power_down_pin,
    input  wire logic       auto_rx_detect_reset,
    output logic [7:0]      channel_power_down,
    output logic            rx_detect_sm_reset,
    output logic            signal_detect_threshold_reg_sel,
    output logic            receiver_detect_mode_reg_sel,
    output logic            channel_settings_write_enable,
    output logic            smbus_master_reset
);

    // Read mux, shared by the first read byte and every following one
    function automatic logic [7:0] read_reg(input rpo_pkg::rpo_regs_t r, input logic [7:0] a);
        logic [7:0] d;
        d = 8'h00;
        unique case (a)
            rpo_pkg::OFS_POWER_DOWN:   d = r.power_down;
            rpo_pkg::OFS_OVERRIDE:     d = r.override_ctl;
            rpo_pkg::OFS_RSVD_A:       d = r.rsvd_a;
            rpo_pkg::OFS_RSVD_B:       d = r.rsvd_b;
            rpo_pkg::OFS_RSVD_C:       d = r.rsvd_c;
            rpo_pkg::OFS_SLAVE_CTRL:   d = r.slave_ctl;
            rpo_pkg::OFS_RESET_CTRL:   d = r.reset_ctl;
            rpo_pkg::OFS_PIN_OVERRIDE: d = r.pin_override;
            default:                   d = 8'h00;
        endcase
        return d;
    endfunction

    rpo_pkg::rpo_state_t state_reg, state_next;
    rpo_pkg::rpo_regs_t  regs_reg, regs_next;
    rpo_pkg::rpo_write_t wr;
    logic [7:0]          shift_reg, shift_next;
    logic [7:0]          ptr_reg, ptr_next;
    logic [3:0]          cnt_reg, cnt_next;
    logic                scl_prev_reg, sda_prev_reg;
    logic                rw_reg, rw_next;
    logic                nack_reg, nack_next;
    logic                oe_reg, oe_next;
    logic                master_rst_reg, master_rst_next;
    logic                scl_rise, scl_fall, start_seen, stop_seen;

    // Bus edges; pins are already in the clock domain
    assign scl_rise   = scl_in & ~scl_prev_reg;
    assign scl_fall   = ~scl_in & scl_prev_reg;
    assign start_seen = scl_in & scl_prev_reg & sda_prev_reg & ~sda_in;
    assign stop_seen  = scl_in & scl_prev_reg & ~sda_prev_reg & sda_in;

    // Bus engine next state; only a start or stop breaks a transfer off
    always_comb begin
        state_next = state_reg;
        shift_next = shift_reg;
        ptr_next   = ptr_reg;
        cnt_next   = cnt_reg;
        rw_next    = rw_reg;
        nack_next  = nack_reg;
        oe_next    = oe_reg;
        wr         = '0;
        if (start_seen) begin
            state_next = rpo_pkg::RPO_ADDR;
            cnt_next   = 4'h0;
            oe_next    = 1'b0;
        end else if (stop_seen) begin
            state_next = rpo_pkg::RPO_IDLE;
            oe_next    = 1'b0;
        end else begin
            unique case (state_reg)
                rpo_pkg::RPO_IDLE: begin
                    oe_next = 1'b0;
                end
                rpo_pkg::RPO_ADDR, rpo_pkg::RPO_OFFSET, rpo_pkg::RPO_WDATA: begin
                    if (scl_rise) begin
                        shift_next = {shift_reg[6:0], sda_in};
                        cnt_next   = cnt_reg + 4'h1;
                    end else if (scl_fall && cnt_reg == rpo_pkg::BYTE_BITS) begin
                        cnt_next = 4'h0;
                        oe_next  = 1'b1;   // Ack drives the line low
                        if (state_reg == rpo_pkg::RPO_ADDR) begin
                            if (shift_reg[7:1] == SLAVE_ADDR) begin
                                rw_next    = shift_reg[0];
                                state_next = rpo_pkg::RPO_ADDR_ACK;
                            end else begin
                                oe_next    = 1'b0;   // Not ours, stay quiet
                                state_next = rpo_pkg::RPO_IDLE;
                            end
                        end else if (state_reg == rpo_pkg::RPO_OFFSET) begin
                            ptr_next   = shift_reg;
                            state_next = rpo_pkg::RPO_OFS_ACK;
                        end else begin
                            wr.en      = 1'b1;   // Commit at the ack, before stop
                            wr.addr    = ptr_reg;
                            wr.data    = shift_reg;
                            ptr_next   = ptr_reg + 8'h01;
                            state_next = rpo_pkg::RPO_WDATA_ACK;
                        end
                    end
                end
                rpo_pkg::RPO_ADDR_ACK: begin
                    if (scl_fall) begin
                        if (rw_reg) begin
                            shift_next = read_reg(regs_reg, ptr_reg);
                            oe_next    = ~shift_next[7];   // Pull low for a zero first bit
                            ptr_next   = ptr_reg + 8'h01;
                            state_next = rpo_pkg::RPO_RDATA;
                        end else begin
                            oe_next    = 1'b0;
                            state_next = rpo_pkg::RPO_OFFSET;
                        end
                    end
                end
                rpo_pkg::RPO_OFS_ACK, rpo_pkg::RPO_WDATA_ACK: begin
                    if (scl_fall) begin
                        oe_next    = 1'b0;
                        state_next = rpo_pkg::RPO_WDATA;
                    end
                end
                rpo_pkg::RPO_RDATA: begin
                    if (scl_rise) begin
                        cnt_next = cnt_reg + 4'h1;
                    end else if (scl_fall) begin
                        if (cnt_reg == rpo_pkg::BYTE_BITS) begin
                            cnt_next   = 4'h0;
                            oe_next    = 1'b0;   // Release for the host's ack
                            state_next = rpo_pkg::RPO_RDATA_ACK;
                        end else begin
                            shift_next = {shift_reg[6:0], 1'b0};
                            oe_next    = ~shift_reg[6];
                        end
                    end
                end
                rpo_pkg::RPO_RDATA_ACK: begin
                    if (scl_rise) begin
                        nack_next = sda_in;
                    end else if (scl_fall) begin
                        if (nack_reg) begin
                            state_next = rpo_pkg::RPO_IDLE;   // Host ends the read
                        end else begin
                            shift_next = read_reg(regs_reg, ptr_reg);
                            oe_next    = ~shift_next[7];
                            ptr_next   = ptr_reg + 8'h01;
                            state_next = rpo_pkg::RPO_RDATA;
                        end
                    end
                end
                default: begin
                    oe_next    = 1'b0;
                    state_next = rpo_pkg::RPO_IDLE;
                end
            endcase
        end
    end

    // Bus engine registers
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state_reg    <= rpo_pkg::RPO_IDLE;
            shift_reg    <= 8'h00;
            ptr_reg      <= 8'h00;
            cnt_reg      <= 4'h0;
            rw_reg       <= 1'b0;
            nack_reg     <= 1'b0;
            oe_reg       <= 1'b0;
            scl_prev_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
        end else begin
            state_reg    <= state_next;
            shift_reg    <= shift_next;
            ptr_reg      <= ptr_next;
            cnt_reg      <= cnt_next;
            rw_reg       <= rw_next;
            nack_reg     <= nack_next;
            oe_reg       <= oe_next;
            scl_prev_reg <= scl_in;
            sda_prev_reg <= sda_in;
        end
    end

    // Register file next state; self-clearing bits are never stored
    always_comb begin
        regs_next       = regs_reg;
        master_rst_next = 1'b0;
        if (wr.en) begin
            unique case (wr.addr)
                rpo_pkg::OFS_POWER_DOWN:   regs_next.power_down   = wr.data;
                rpo_pkg::OFS_OVERRIDE:     regs_next.override_ctl = wr.data;
                rpo_pkg::OFS_RSVD_A:       regs_next.rsvd_a       = wr.data;
                rpo_pkg::OFS_RSVD_B:       regs_next.rsvd_b       = wr.data;
                rpo_pkg::OFS_RSVD_C:       regs_next.rsvd_c       = wr.data;
                rpo_pkg::OFS_SLAVE_CTRL:   regs_next.slave_ctl    = wr.data;
                rpo_pkg::OFS_RESET_CTRL: begin
                    // Host keeps the low bits at their pattern; we just store them
                    regs_next.reset_ctl = wr.data;
                    regs_next.reset_ctl[rpo_pkg::BIT_RESET_REGISTERS] = 1'b0;
                    regs_next.reset_ctl[rpo_pkg::BIT_RESET_MASTER]    = 1'b0;
                    master_rst_next = wr.data[rpo_pkg::BIT_RESET_MASTER];
                    if (wr.data[rpo_pkg::BIT_RESET_REGISTERS]) begin
                        regs_next = rpo_pkg::RST_REGS;   // Bus engine untouched
                    end
                end
                rpo_pkg::OFS_PIN_OVERRIDE: regs_next.pin_override = wr.data;
                default:                   regs_next = regs_reg;
            endcase
        end
    end

    // Register file flops
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            regs_reg       <= rpo_pkg::RST_REGS;
            master_rst_reg <= 1'b0;
        end else begin
            regs_reg       <= regs_next;
            master_rst_reg <= master_rst_next;
        end
    end

    // Open drain: only ever pulls low
    assign sda_out = 1'b0;
    assign sda_oe  = oe_reg;

    // Pin versus register selection
    assign channel_power_down = regs_reg.override_ctl[rpo_pkg::BIT_OVR_POWER_DOWN] ?
                                regs_reg.power_down : channel_power_down_pin;
    assign rx_detect_sm_reset = regs_reg.override_ctl[rpo_pkg::BIT_OVR_PRESENT] ?
                                regs_reg.override_ctl[rpo_pkg::BIT_PRESENT_VALUE] :
                                auto_rx_detect_reset;
    assign signal_detect_threshold_reg_sel =
        regs_reg.pin_override[rpo_pkg::BIT_OVR_THRESHOLD];
    assign receiver_detect_mode_reg_sel =
        regs_reg.pin_override[rpo_pkg::BIT_OVR_RX_DETECT];
    // Gates the channel swing, de-emphasis and equalizer registers held elsewhere
    assign channel_settings_write_enable =
        regs_reg.slave_ctl[rpo_pkg::BIT_REG_ENABLE];
    assign smbus_master_reset = master_rst_reg;

endmodule // rpo_override_regs

`default_nettype wire

/* rpo_override_regs_properties.sv */
// Checker for the override register bank, watching its ports only
`timescale 1ns/100ps
`default_nettype none
module rpo_override_regs_properties (
    input wire logic       clock,
    input wire logic       nrst,
    input wire logic       scl_in,
    input wire logic       sda_in,
    input wire logic       sda_out,
    input wire logic       sda_oe,
    input wire logic [7:0] channel_power_down_pin,
    input wire logic       auto_rx_detect_reset,
    input wire logic [7:0] channel_power_down,
    input wire logic       rx_detect_sm_reset,
    input wire logic       signal_detect_threshold_reg_sel,
    input wire logic       receiver_detect_mode_reg_sel,
    input wire logic       channel_settings_write_enable,
    input wire logic       smbus_master_reset
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    // Master reset pulse is one cycle, then gone
    sequence s_one_pulse;
        smbus_master_reset ##1 !smbus_master_reset;
    endsequence
    chk_master_pulse_one:
        assert property ($rose(smbus_master_reset) |-> s_one_pulse) else $error("master pulse too long");
    chk_master_at_ack:
        assert property (smbus_master_reset |-> $rose(sda_oe)) else $error("master pulse off ack");
    chk_open_drain_low:
        assert property (sda_out == 1'b0) else $error("data output not low");
    // Data line may move only while the bus clock is low
    chk_sda_scl_low:
        assert property ($changed(sda_oe) |-> !scl_in) else $error("data moved with clock high");
    chk_enable_at_ack:
        assert property ($changed(channel_settings_write_enable) |-> sda_oe) else $error("enable moved");
    chk_select_at_ack:
        assert property ($changed({signal_detect_threshold_reg_sel, receiver_detect_mode_reg_sel})
            |-> sda_oe) else $error("select moved off ack");
    // Once registers govern, pin changes must not leak through
    chk_pd_reg_hold:
        assert property ((channel_power_down != channel_power_down_pin)
            |-> $stable(channel_power_down) || sda_oe) else $error("power down followed pin");
    chk_detect_reg_hold:
        assert property ((rx_detect_sm_reset != auto_rx_detect_reset)
            |-> $stable(rx_detect_sm_reset) || sda_oe) else $error("detect reset followed input");
    chk_reset_quiet:
        assert property ($rose(nrst) |-> !sda_oe && !smbus_master_reset
            && !channel_settings_write_enable && !signal_detect_threshold_reg_sel
            && !receiver_detect_mode_reg_sel) else $error("outputs not at default after reset");
endmodule // rpo_override_regs_properties
bind rpo_override_regs rpo_override_regs_properties i_props (
    .clock(clock), .nrst(nrst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .channel_power_down_pin(channel_power_down_pin),
    .auto_rx_detect_reset(auto_rx_detect_reset), .channel_power_down(channel_power_down),
    .rx_detect_sm_reset(rx_detect_sm_reset),
    .signal_detect_threshold_reg_sel(signal_detect_threshold_reg_sel),
    .receiver_detect_mode_reg_sel(receiver_detect_mode_reg_sel),
    .channel_settings_write_enable(channel_settings_write_enable),
    .smbus_master_reset(smbus_master_reset));
`default_nettype wire

/* rpo_smbus_host.sv */
// SMBus host model driving clock and data from the far side
`timescale 1ns/100ps
`default_nettype none
module rpo_smbus_host #(
    parameter logic [6:0] ADDR = 7'h18
) (
    input  wire logic clock,
    input  wire logic sda,
    output var logic  scl,
    output var logic  sda_lo
);
    // Both lines released at start; pull-ups hold them high
    initial begin
        scl = 1'b1;
        sda_lo = 1'b0;
    end
    // Lines change only just after a clock edge, then hold
    task automatic drv(input logic c, input logic lo, input int n);
        scl <= c;
        sda_lo <= lo;
        repeat (n) @(posedge clock);
    endtask
    // One bit: data set while clock low, sampled late in the high phase
    task automatic xbit(input logic b, output logic r);
        drv(1'b0, ~b, 3);
        drv(1'b1, ~b, 3);
        r = sda;
        drv(1'b0, ~b, 1);
    endtask
    task automatic start();
        drv(scl, 1'b0, 2);
        drv(1'b1, 1'b0, 3);
        drv(1'b1, 1'b1, 3);
        drv(1'b0, 1'b1, 1);
    endtask
    task automatic stop();
        drv(1'b0, 1'b1, 2);
        drv(1'b1, 1'b1, 3);
        drv(1'b1, 1'b0, 4);
    endtask
    // Byte out, most significant bit first, then the device's ack
    task automatic send(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) xbit(d[i], r);
        xbit(1'b1, r);
        ack = ~r;
    endtask
    task automatic write_reg(input logic [6:0] a, input logic [7:0] o, input logic [7:0] d,
                             output logic ok);
        logic k1, k2, k3;
        start();
        send({a, 1'b0}, k1);
        send(o, k2);
        send(d, k3);
        stop();
        ok = k1 & k2 & k3;
    endtask
    // Single-byte read ending with a nack
    task automatic read_reg(input logic [7:0] o, output logic [7:0] d, output logic ok);
        logic k1, k2, k3, r;
        start();
        send({ADDR, 1'b0}, k1);
        send(o, k2);
        start();
        send({ADDR, 1'b1}, k3);
        for (int i = 7; i >= 0; i--) xbit(1'b1, d[i]);
        xbit(1'b1, r);
        stop();
        ok = k1 & k2 & k3;
    endtask
endmodule // rpo_smbus_host
`default_nettype wire

/* rpo_override_regs_tb.sv */
// Self-checking bench for the override and reset register bank
`timescale 1ns/100ps
`default_nettype none
module rpo_override_regs_tb;
    logic       clock, nrst, scl, sda_lo, auto_rst, sda_oe, sda_out, ok;
    logic       rx_det, thr_sel, mode_sel, wen, mrst;
    logic [7:0] pd_pin, pd_out, rd;
    wire        sda;
    int         err_total = 0, checked = 0, pulses = 0, cycles = 0;
    logic [7:0] dflt [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h10, 8'h01, 8'h00, 8'h00};
    // Open-drain data with pull-up: low if either party pulls
    assign sda = ~sda_lo & ~(sda_oe & ~sda_out);
    rpo_override_regs i_rpo_override_regs (
        .clock(clock), .nrst(nrst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
        .sda_oe(sda_oe), .channel_power_down_pin(pd_pin), .auto_rx_detect_reset(auto_rst),
        .channel_power_down(pd_out), .rx_detect_sm_reset(rx_det),
        .signal_detect_threshold_reg_sel(thr_sel), .receiver_detect_mode_reg_sel(mode_sel),
        .channel_settings_write_enable(wen), .smbus_master_reset(mrst));
    rpo_smbus_host #(.ADDR(rpo_pkg::DEFAULT_SLAVE_ADDR)) i_host (
        .clock(clock), .sda(sda), .scl(scl), .sda_lo(sda_lo));
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    // Pulse count and hang guard; the full run needs about 9600 cycles
    always @(posedge clock) begin
        cycles++;
        if (mrst === 1'b1) pulses++;
        if (cycles == 60000) begin
            err_total++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("checked %0d err_total %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic cmp(input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: expected %h got %h", $time, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] o, input logic [7:0] d);
        i_host.write_reg(rpo_pkg::DEFAULT_SLAVE_ADDR, o, d, ok);
        cmp(8'h01, {7'h00, ok});
    endtask
    task automatic rdc(input logic [7:0] o, input logic [7:0] exp);
        i_host.read_reg(o, rd, ok);
        cmp(8'h01, {7'h00, ok});
        cmp(exp, rd);
    endtask
    // Selection outputs packed: detect reset, threshold, mode, enable
    function automatic logic [7:0] sel();
        return {4'h0, rx_det, thr_sel, mode_sel, wen};
    endfunction
    initial begin
        nrst = 1'b0;
        pd_pin = 8'h00;
        auto_rst = 1'b0;
        repeat (12) @(posedge clock);
        nrst <= 1'b1;
        repeat (2) @(posedge clock);
        // Defaults, reserved and unmapped offsets included
        for (int i = 0; i < 10; i++) rdc(8'(i), dflt[i]);
        pd_pin <= 8'h5a;
        auto_rst <= 1'b1;
        repeat (2) @(posedge clock);
        cmp(8'h5a, pd_out);
        cmp(8'h08, sel());
        wr(8'h01, 8'ha5);
        cmp(8'h5a, pd_out);
        wr(8'h02, 8'h01);
        cmp(8'ha5, pd_out);
        wr(8'h02, 8'h80);
        cmp(8'h00, sel());
        auto_rst <= 1'b0;
        wr(8'h02, 8'hc1);
        cmp(8'h08, sel());
        rdc(8'h02, 8'hc1);
        wr(8'h06, 8'h18);
        cmp(8'h09, sel());
        wr(8'h08, 8'h48);
        cmp(8'h0f, sel());
        wr(8'h08, 8'h08);
        cmp(8'h0b, sel());
        for (int i = 3; i < 6; i++) wr(8'(i), 8'(8'h3c + i));
        for (int i = 3; i < 6; i++) rdc(8'(i), 8'(8'h3c + i));
        cmp(8'ha5, pd_out);
        // Pin moves while the register governs; output must not follow
        pd_pin <= 8'hc3;
        repeat (2) @(posedge clock);
        cmp(8'ha5, pd_out);
        pd_pin <= 8'h5a;
        wr(8'h07, 8'h21);
        cmp(8'h01, 8'(pulses));
        rdc(8'h07, 8'h01);
        cmp(8'h0b, sel());
        wr(8'h07, 8'h41);
        for (int i = 1; i < 9; i++) rdc(8'(i), dflt[i]);
        cmp(8'h5a, pd_out);
        cmp(8'h00, sel());
        cmp(8'h01, 8'(pulses));
        i_host.write_reg(7'h19, 8'h06, 8'h18, ok);
        cmp(8'h00, {7'h00, ok});
        cmp(8'h00, sel());
        // Mid-run reset with the bus idle must bring back the defaults
        wr(8'h08, 8'h48);
        cmp(8'h06, sel());
        nrst <= 1'b0;
        repeat (3) @(posedge clock);
        nrst <= 1'b1;
        repeat (2) @(posedge clock);
        cmp(8'h00, sel());
        rdc(8'h08, 8'h00);
        print_verdict();
    end
endmodule // rpo_override_regs_tb
`default_nettype wire
